// ==== src/cmb_regs.vh ====
// register offsets, field positions and limits of the message buffer image
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`ifndef CMB_REGS_VH
`define CMB_REGS_VH
`define CMB_OFF_IDENT_0   4'h0
`define CMB_OFF_IDENT_1   4'h1
`define CMB_OFF_IDENT_2   4'h2
`define CMB_OFF_IDENT_3   4'h3
`define CMB_OFF_PAY_FIRST 4'h4
`define CMB_OFF_PAY_LAST  4'hb
`define CMB_OFF_LENGTH    4'hc
`define CMB_OFF_STATUS    4'hd
`define CMB_BIT_REMOTE    4
`define CMB_BIT_EXT       3
`define CMB_MAX_BYTES     4'h8
`define CMB_ID_BITS       11
`endif

// ==== src/cmb_bit_shifter.v ====
// parallel-load shift register, msb first out, msb first in
`timescale 1ns/1ns
`default_nettype none
module cmb_bit_shifter #(
  parameter W = 8
) (
  // clock and reset
  input  wire         i_clk,
  input  wire         i_sys_rst,
  // control
  input  wire         i_load,
  input  wire [W-1:0] i_value,
  input  wire         i_shift,
  input  wire         i_bit,
  // state
  output wire         o_msb,
  output wire [W-1:0] o_value
);
  reg [W-1:0] sh_q;

  // load has priority over shift
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      sh_q <= {W{1'b0}};
    else if (i_load)
      sh_q <= i_value;
    else if (i_shift)
      sh_q <= {sh_q[W-2:0], i_bit};
  end

  assign o_msb   = sh_q[W-1];
  assign o_value = sh_q;
endmodule
`default_nettype wire

// ==== src/cmb_message_buffer.v ====
// standard-identifier can message buffer with serial bit engine port
`timescale 1ns/1ns
`default_nettype none
`include "cmb_regs.vh"
module cmb_message_buffer (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_sys_rst,
  // register port
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // bus engine: transmit side
  input  wire       i_tx_start,
  input  wire       i_tx_adv,
  output reg        o_tx_bit,
  output reg        o_tx_busy,
  output reg        o_tx_done,
  // bus engine: receive side
  input  wire       i_rx_start,
  input  wire       i_rx_valid,
  input  wire       i_rx_bit,
  output reg        o_rx_busy,
  output reg        o_rx_done,
  // arbitration compare
  input  wire [10:0] i_arb_id,
  output reg        o_arb_win
);
  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  localparam S_IDLE = 5'h01;
  localparam S_ID   = 5'h02;
  localparam S_CTRL = 5'h04;
  localparam S_LEN  = 5'h08;
  localparam S_DATA = 5'h10;

  reg  [7:0] id0_q, id1_q, id2_q, id3_q, len_q;
  reg  [7:0] pay_q [0:7];
  reg  [4:0] st_q;
  reg  [3:0] cnt_q;
  reg  [2:0] byte_q;
  reg  [3:0] nbytes_q;
  reg        rx_mode_q;
  reg  [3:0] rx_len_q;
  reg  [1:0] rx_flags_q;
  wire       adv = rx_mode_q ? i_rx_valid : i_tx_adv;
  wire [10:0] frame_identifier = {id0_q, id1_q[7:5]};
  wire [3:0] code_len = len_q[3:0];
  // clamp to eight bytes; code is plain binary count
  wire [3:0] data_cnt = (code_len > `CMB_MAX_BYTES) ? `CMB_MAX_BYTES
                                                    : code_len;
  // the last length bit is still on the pin when the count is taken
  wire [3:0] rx_code = {rx_len_q[2:0], i_rx_bit};
  wire [3:0] rx_cnt = (rx_code > `CMB_MAX_BYTES) ? `CMB_MAX_BYTES
                                                 : rx_code;
  wire       sh_msb;
  wire [7:0] sh_val;
  reg        sh_load;
  reg  [7:0] sh_in;
  wire       busy = (st_q != S_IDLE);

  // ---------------------------------------------------------------------------
  // shifter shared by transmit and receive
  // ---------------------------------------------------------------------------
  cmb_bit_shifter #(.W(8)) u_shift (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    (sh_load),
    .i_value   (sh_in),
    .i_shift   (busy & adv),
    .i_bit     (i_rx_bit),
    .o_msb     (sh_msb),
    .o_value   (sh_val)
  );

  // pick the next byte to load into the shifter on transmit
  always @*
  begin
    sh_load = 1'b0;
    sh_in   = 8'h00;
    if (i_tx_start && !busy)
    begin
      sh_load = 1'b1;
      sh_in   = id0_q;
    end
    else if (busy && adv && !rx_mode_q && cnt_q == 4'h0)
    begin
      sh_load = 1'b1;
      case (st_q)
        S_ID:    sh_in = {id1_q[7:5], 5'h00};
        S_CTRL:  sh_in = {len_q[3:0], 4'h0};
        // byte index is only reset as the length ends, so name byte 0 here
        S_LEN:   sh_in = pay_q[0];
        default: sh_in = pay_q[byte_q + 3'h1];
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // frame sequencer
  // ---------------------------------------------------------------------------
  // tx order: 11 id bits, remote, format, 4 length bits, payload bits
  // the shifter presents the next bit on its msb, except the remote and format bits
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      st_q      <= S_IDLE;
      cnt_q     <= 4'h0;
      byte_q    <= 3'h0;
      nbytes_q  <= 4'h0;
      rx_mode_q <= 1'b0;
      rx_len_q  <= 4'h0;
      rx_flags_q <= 2'h0;
      o_tx_done <= 1'b0;
      o_rx_done <= 1'b0;
    end
    else
    begin
      o_tx_done <= 1'b0;
      o_rx_done <= 1'b0;
      case (st_q)
        S_IDLE:
          if (i_tx_start)
          begin
            st_q      <= S_ID;
            rx_mode_q <= 1'b0;
            cnt_q     <= 4'h7;
            // remote frame carries no payload bytes
            nbytes_q  <= id1_q[`CMB_BIT_REMOTE] ? 4'h0 : data_cnt;
          end
          else if (i_rx_start)
          begin
            st_q      <= S_ID;
            rx_mode_q <= 1'b1;
            cnt_q     <= 4'h7;
          end
        S_ID:
          if (adv)
          begin
            if (cnt_q == 4'h0)
            begin
              st_q  <= S_CTRL;
              cnt_q <= 4'h4;     // 3 id bits, then remote and format
            end
            else
              cnt_q <= cnt_q - 4'h1;
          end
        S_CTRL:
          if (adv)
          begin
            // on rx, the remote and format bits follow the id
            if (rx_mode_q && cnt_q == 4'h1)
              rx_flags_q[1] <= i_rx_bit;
            if (rx_mode_q && cnt_q == 4'h0)
              rx_flags_q[0] <= i_rx_bit;
            if (cnt_q == 4'h0)
            begin
              st_q  <= S_LEN;
              cnt_q <= 4'h3;
            end
            else
              cnt_q <= cnt_q - 4'h1;
          end
        S_LEN:
          if (adv)
          begin
            if (rx_mode_q)
              rx_len_q <= {rx_len_q[2:0], i_rx_bit};
            if (cnt_q == 4'h0)
            begin
              byte_q <= 3'h0;
              cnt_q  <= 4'h7;
              if (rx_mode_q)
                nbytes_q <= rx_flags_q[1] ? 4'h0 : rx_cnt;
              if ((rx_mode_q && (rx_flags_q[1] || rx_cnt == 4'h0)) ||
                  (!rx_mode_q && nbytes_q == 4'h0))
              begin
                st_q      <= S_IDLE;
                o_tx_done <= !rx_mode_q;
                o_rx_done <= rx_mode_q;
              end
              else
                st_q <= S_DATA;
            end
            else
              cnt_q <= cnt_q - 4'h1;
          end
        S_DATA:
          if (adv)
          begin
            if (cnt_q == 4'h0)
            begin
              cnt_q  <= 4'h7;
              byte_q <= byte_q + 3'h1;
              if ({1'b0, byte_q} + 4'h1 >= nbytes_q)
              begin
                st_q      <= S_IDLE;
                o_tx_done <= !rx_mode_q;
                o_rx_done <= rx_mode_q;
              end
            end
            else
              cnt_q <= cnt_q - 4'h1;
          end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // the control byte shift order: remote, format, then length
  // tx bit: msb of shifter, but ctrl bits come from the image directly
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_tx_bit <= 1'b1;
    else if (!busy || rx_mode_q)
      o_tx_bit <= 1'b1;
    else if (st_q == S_CTRL && cnt_q == 4'h1)
      o_tx_bit <= id1_q[`CMB_BIT_REMOTE];
    else if (st_q == S_CTRL && cnt_q == 4'h0)
      o_tx_bit <= id1_q[`CMB_BIT_EXT];
    else
      o_tx_bit <= sh_msb;
  end

  // ---------------------------------------------------------------------------
  // arbitration and status outputs
  // ---------------------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_arb_win <= 1'b0;
      o_tx_busy <= 1'b0;
      o_rx_busy <= 1'b0;
    end
    else
    begin
      o_arb_win <= (frame_identifier < i_arb_id);
      o_tx_busy <= busy & !rx_mode_q;
      o_rx_busy <= busy & rx_mode_q;
    end
  end

  // ---------------------------------------------------------------------------
  // register image: software writes, receive fills
  // ---------------------------------------------------------------------------
  integer k;
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      id0_q <= 8'h00;
      id1_q <= 8'h00;
      id2_q <= 8'h00;
      id3_q <= 8'h00;
      len_q <= 8'h00;
      for (k = 0; k < 8; k = k + 1)
        pay_q[k] <= 8'h00;
    end
    else
    begin
      if (i_wr)
      begin
        case (i_addr)
          `CMB_OFF_IDENT_0: id0_q <= i_wdata;
          `CMB_OFF_IDENT_1: id1_q <= i_wdata;
          `CMB_OFF_IDENT_2: id2_q <= i_wdata;
          `CMB_OFF_IDENT_3: id3_q <= i_wdata;
          `CMB_OFF_LENGTH:  len_q <= {4'h0, i_wdata[3:0]};
          default:
            if (i_addr >= `CMB_OFF_PAY_FIRST && i_addr <= `CMB_OFF_PAY_LAST)
              pay_q[i_addr[2:0] - 3'h4] <= i_wdata;
        endcase
      end
      // receive writes win over a software write in the same cycle
      if (rx_mode_q && busy && i_rx_valid)
      begin
        if (st_q == S_ID && cnt_q == 4'h0)
          id0_q <= {sh_val[6:0], i_rx_bit};
        if (st_q == S_CTRL && cnt_q == 4'h0)
          id1_q <= {sh_val[3:1], rx_flags_q[1], i_rx_bit, 3'h0};
        if (st_q == S_LEN && cnt_q == 4'h0)
          len_q <= {4'h0, rx_len_q[2:0], i_rx_bit};
        if (st_q == S_DATA && cnt_q == 4'h0)
          pay_q[byte_q] <= {sh_val[6:0], i_rx_bit};
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        `CMB_OFF_IDENT_0: o_rdata <= id0_q;
        `CMB_OFF_IDENT_1: o_rdata <= id1_q;
        `CMB_OFF_IDENT_2: o_rdata <= id2_q;
        `CMB_OFF_IDENT_3: o_rdata <= id3_q;
        `CMB_OFF_LENGTH:  o_rdata <= len_q;
        `CMB_OFF_STATUS:  o_rdata <= {6'h00, busy & rx_mode_q, busy & !rx_mode_q};
        default:
          if (i_addr >= `CMB_OFF_PAY_FIRST && i_addr <= `CMB_OFF_PAY_LAST)
            o_rdata <= pay_q[i_addr[2:0] - 3'h4];
          else
            o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// ==== bench/cmb_message_buffer_asserts.sv ====
// port checker for the message buffer
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------------
// checker
// ---------------------------------------------------------------------------
module cmb_mb_asserts (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  // watched ports
  input wire logic [3:0]  i_addr,
  input wire logic        i_rd,
  input wire logic        i_tx_start,
  input wire logic        i_tx_adv,
  input wire logic [10:0] i_arb_id,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_tx_bit,
  input wire logic        o_tx_busy,
  input wire logic        o_tx_done,
  input wire logic        o_rx_busy,
  input wire logic        o_rx_done,
  input wire logic        o_arb_win
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // read port answers only in the cycle after a strobe
  a_rd_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 4'hd |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_len_upper: assert property ($past(i_rd) && $past(i_addr) == 4'hc |-> o_rdata[7:4] == 4'h0)
    else $error("length upper bits set");
  // nothing is smaller than identifier zero
  a_arb_floor: assert property ($past(i_arb_id) == 11'h000 |-> !o_arb_win)
    else $error("won against identifier zero");
  // serial side: start, hold between bit times, idle level, end pulse
  a_tx_starts: assert property (i_tx_start && !o_tx_busy && !o_rx_busy |=> ##1 o_tx_busy)
    else $error("transmit did not start");
  // the pin follows an advance two edges later: shift, then output register
  a_bit_holds: assert property (o_tx_busy && $past(o_tx_busy) && !$past(i_tx_adv, 2) |-> $stable(o_tx_bit))
    else $error("bit changed without advance");
  a_idle_high: assert property (!o_tx_busy && !$past(o_tx_busy) |-> o_tx_bit)
    else $error("idle line not recessive");
  a_done_pulse: assert property (o_tx_done |=> !o_tx_done)
    else $error("transmit end longer than one cycle");
  a_done_after_busy: assert property (o_tx_done |-> $past(o_tx_busy))
    else $error("transmit end without frame");
  a_rx_pulse: assert property (o_rx_done |=> !o_rx_done)
    else $error("receive end longer than one cycle");
  a_rx_end_busy: assert property (o_rx_done |-> $past(o_rx_busy))
    else $error("receive end without frame");
  a_dir_exclusive: assert property (!(o_rx_busy && o_tx_busy))
    else $error("transmit and receive busy together");
endmodule
bind cmb_message_buffer cmb_mb_asserts u_chk (.i_clk, .i_sys_rst, .i_addr, .i_rd, .i_tx_start,
  .i_tx_adv, .i_arb_id, .o_rdata, .o_tx_bit, .o_tx_busy, .o_tx_done, .o_rx_busy, .o_rx_done,
  .o_arb_win);
`default_nettype wire

// ==== bench/cmb_far_node.sv ====
// far-side node model: paces transmit bits and plays receive frames
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------------
// far node
// ---------------------------------------------------------------------------
module cmb_far_node (
  // clock and device serial side
  input  wire logic i_clk,
  input  wire logic i_tx_bit,
  input  wire logic i_tx_busy,
  // strobes into the device
  output var  logic o_tx_adv,
  output var  logic o_rx_start,
  output var  logic o_rx_valid,
  output var  logic o_rx_bit
);
  logic [127:0] cap;
  int           n_cap;
  int           gap;
  int           pace;
  // quiet bus at time zero
  initial
  begin
    o_tx_adv   = 1'b0;
    o_rx_start = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_bit   = 1'b1;
    cap        = '0;
    n_cap      = 0;
    gap        = 0;
    pace       = 2;
  end
  // bit time counts every cycle, but advance is only raised while transmit is busy, so no stray advance
  always @(posedge i_clk)
  begin
    gap      <= o_tx_adv ? 0 : gap + 1;
    o_tx_adv <= i_tx_busy && !o_tx_adv && gap >= pace;
    if (o_tx_adv)
    begin
      cap   <= {cap[126:0], i_tx_bit};
      n_cap <= n_cap + 1;
    end
  end
  // send n bits msb first; between bit times the line shows the inverse
  task automatic send(input logic [80:0] v, input int n);
    @(posedge i_clk);
    o_rx_start <= 1'b1;
    @(posedge i_clk);
    o_rx_start <= 1'b0;
    for (int k = n - 1; k >= 0; k--)
    begin
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_bit   <= v[k];
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      o_rx_bit   <= ~v[k];
    end
  endtask
endmodule
`default_nettype wire

// ==== bench/test_cmb_message_buffer.sv ====
// self-checking bench for the message buffer
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------------
// bench
// ---------------------------------------------------------------------------
module test_cmb_message_buffer;
  logic        i_clk;
  logic        i_sys_rst;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic        i_tx_start;
  logic [10:0] i_arb_id;
  wire  [7:0]  o_rdata;
  wire         i_tx_adv, i_rx_start, i_rx_valid, i_rx_bit;
  wire         o_tx_bit, o_tx_busy, o_tx_done, o_rx_busy, o_rx_done, o_arb_win;
  int          n_mismatch;
  int          checks_done;
  cmb_message_buffer u_dut (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_tx_start, .i_tx_adv, .o_tx_bit, .o_tx_busy, .o_tx_done, .i_rx_start, .i_rx_valid,
    .i_rx_bit, .o_rx_busy, .o_rx_done, .i_arb_id, .o_arb_win);
  cmb_far_node u_far (.i_clk, .i_tx_bit(o_tx_bit), .i_tx_busy(o_tx_busy), .o_tx_adv(i_tx_adv),
    .o_rx_start(i_rx_start), .o_rx_valid(i_rx_valid), .o_rx_bit(i_rx_bit));
  // 25 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // register port: one-cycle strobes, read data taken in the answer cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask
  // bounded wait for a one-cycle frame end pulse
  task automatic wait_done(input logic rx);
    int t;
    t = 0;
    while ((rx ? o_rx_done : o_tx_done) !== 1'b1)
    begin
      @(posedge i_clk);
      #1;
      t++;
      if (t > 3000)
      begin
        n_mismatch++;
        $display("unexpected at %0t: no frame end", $time);
        complete_run;
      end
    end
  endtask
  // every offset written then read; length keeps its low nibble only
  task automatic t_regs;
    for (int k = 0; k < 16; k++) wr(k[3:0], 8'h5a + k[7:0]);
    for (int k = 0; k < 16; k++)
      rdc(k[3:0], k == 12 ? 8'h06 : (k > 12 ? 8'h00 : 8'h5a + k[7:0]));
  endtask
  // transmit one frame and compare the whole bit stream
  task automatic t_tx(input logic [10:0] id, input logic rtr, input logic [3:0] len, input int p);
    logic [127:0] ev;
    int           nb;
    ev = {id, rtr, 1'b0, len};
    nb = rtr ? 0 : (len > 4'h8 ? 8 : len);
    wr(4'h0, id[10:3]);
    wr(4'h1, {id[2:0], rtr, 4'h0});
    wr(4'hc, {4'h0, len});
    for (int k = 0; k < 8; k++) wr(4'h4 + k[3:0], 8'hc3 ^ k[7:0]);
    for (int k = 0; k < nb; k++) ev = {ev[119:0], 8'hc3 ^ k[7:0]};
    u_far.pace  = p;
    u_far.n_cap = 0;
    @(posedge i_clk);
    i_tx_start <= 1'b1;
    @(posedge i_clk);
    i_tx_start <= 1'b0;
    wait_done(1'b0);
    chk(u_far.n_cap, 17 + 8 * nb);
    chk(u_far.cap & ((128'h1 << (17 + 8 * nb)) - 1), ev);
  endtask
  // receive one frame from the far node and read the image back
  task automatic t_rx(input logic [10:0] id, input logic rtr, input logic [3:0] len);
    logic [80:0] v;
    int          nb;
    nb = rtr ? 0 : len;
    v  = {id, rtr, 1'b0, len};
    for (int k = 0; k < nb; k++) v = {v[72:0], 8'h96 ^ k[7:0]};
    fork
      u_far.send(v, 17 + 8 * nb);
      wait_done(1'b1);
    join
    rdc(4'h0, id[10:3]);
    rdc(4'h1, {id[2:0], rtr, 4'h0});
    rdc(4'hc, {4'h0, len});
    for (int k = 0; k < nb; k++) rdc(4'h4 + k[3:0], 8'h96 ^ k[7:0]);
  endtask
  task automatic arb(input logic [10:0] c, input logic w);
    @(posedge i_clk);
    i_arb_id <= c;
    repeat (2) @(posedge i_clk);
    #1;
    chk(o_arb_win, w);
  endtask
  // main sequence
  initial
  begin
    i_sys_rst   = 1'b1;
    i_addr      = 4'h0;
    i_wdata     = 8'h00;
    i_wr        = 1'b0;
    i_rd        = 1'b0;
    i_tx_start  = 1'b0;
    i_arb_id    = 11'h7ff;
    n_mismatch  = 0;
    checks_done = 0;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_regs;
    t_tx(11'h5a3, 1'b0, 4'h3, 2);
    t_tx(11'h7ff, 1'b0, 4'hf, 6);
    t_tx(11'h001, 1'b1, 4'h5, 2);
    t_tx(11'h000, 1'b0, 4'h0, 3);
    t_tx(11'h2aa, 1'b0, 4'h8, 2);
    t_rx(11'h2c5, 1'b0, 4'h2);
    t_rx(11'h13a, 1'b1, 4'h3);
    wr(4'h0, 8'h20);
    wr(4'h1, 8'h00);
    arb(11'h101, 1'b1);
    arb(11'h100, 1'b0);
    arb(11'h000, 1'b0);
    complete_run;
  end
endmodule
`default_nettype wire
